// *** logic/bmcs_pkg.sv ***
// Constants for the bus master control/status register bank.
// Assumes byte offsets on the documented register port and one PCI clock domain.
package bmcs_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0]  BMCS_OFS_MCS      = 8'h3C;
    localparam logic [7:0]  BMCS_OFS_INTCS    = 8'h40;

    // Reset values
    localparam logic [31:0] BMCS_MCS_RESET    = 32'h000000E6;
    localparam logic [31:0] BMCS_INTCS_RESET  = 32'h00000000;

    // master_control_status status bits (read only)
    localparam int BMCS_B_P2A_FULL    = 0;
    localparam int BMCS_B_P2A_FREE4   = 1;
    localparam int BMCS_B_P2A_EMPTY   = 2;
    localparam int BMCS_B_A2P_FULL    = 3;
    localparam int BMCS_B_A2P_LOAD4   = 4;
    localparam int BMCS_B_A2P_EMPTY   = 5;
    localparam int BMCS_B_P2A_TCZERO  = 6;
    localparam int BMCS_B_A2P_TCZERO  = 7;
    // master_control_status control bits
    localparam int BMCS_B_WR_PRIO     = 8;
    localparam int BMCS_B_WR_EN       = 10;
    localparam int BMCS_B_WR_FOUR     = 11;
    localparam int BMCS_B_RD_EN       = 14;
    localparam int BMCS_B_RD_FOUR     = 15;
    localparam int BMCS_B_NV_DATA_LO  = 16;
    localparam int BMCS_B_ADDON_RST   = 24;
    localparam int BMCS_B_CLR_A2P     = 25;
    localparam int BMCS_B_CLR_P2A     = 26;
    localparam int BMCS_B_CLR_MBOX    = 27;
    localparam int BMCS_B_NV_CODE_LO  = 29;
    localparam int BMCS_B_NV_GO       = 31;

    // interrupt_control_status outgoing mailbox fields
    localparam int BMCS_B_OB_BYTE_LO  = 0;
    localparam int BMCS_B_OB_SEL_LO   = 2;
    localparam int BMCS_B_OB_EN       = 4;
    localparam int BMCS_B_OB_FLAG     = 16;
    localparam int BMCS_B_INT_ANY     = 23;

    // Low two bits of the nonvolatile control code (top bit is go/busy)
    localparam logic [1:0]  BMCS_NV_LOAD_LO   = 2'h0;
    localparam logic [1:0]  BMCS_NV_LOAD_HI   = 2'h1;
    localparam logic [1:0]  BMCS_NV_WRITE     = 2'h2;
    localparam logic [1:0]  BMCS_NV_READ      = 2'h3;

    typedef enum logic [1:0] {
        BMCS_NV_IDLE,
        BMCS_NV_LOAD,
        BMCS_NV_ACCESS
    } bmcs_nv_state_t;

endpackage : bmcs_pkg

// *** logic/bmcs_regs.sv ***
// Bus master control/status and outgoing mailbox interrupt registers.
// Assumes FIFO, transfer count and mailbox inputs come from logic on the PCI clock.
module bmcs_regs
    import bmcs_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    // Register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [3:0]  reg_be_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // FIFO and transfer count status
    input  wire logic        p2a_full_i,
    input  wire logic        p2a_free4_i,
    input  wire logic        p2a_empty_i,
    input  wire logic        a2p_full_i,
    input  wire logic        a2p_load4_i,
    input  wire logic        a2p_empty_i,
    input  wire logic        p2a_tczero_i,
    input  wire logic        a2p_tczero_i,
    // Bus master engine
    input  wire logic        wr_pending_i,
    input  wire logic        rd_pending_i,
    output logic             master_req_o,
    output logic             master_dir_wr_o,
    // Add-On side controls
    output logic             addon_reset_o,
    output logic             clr_a2p_flags_o,
    output logic             clr_p2a_flags_o,
    output logic             clr_mbox_flags_o,
    // Add-On outgoing mailbox reads
    input  wire logic        ob_rd_i,
    input  wire logic [1:0]  ob_idx_i,
    input  wire logic [3:0]  ob_be_i,
    output logic             pci_int_o,
    // External nonvolatile store port
    output logic             nv_req_o,
    output logic             nv_we_o,
    output logic      [15:0] nv_addr_o,
    output logic      [7:0]  nv_wdata_o,
    input  wire logic [7:0]  nv_rdata_i,
    input  wire logic        nv_done_i
);
    import bmcs_pkg::*;

    typedef struct packed {
        logic           wr_prio;
        logic           wr_en;
        logic           wr_four;
        logic           rd_en;
        logic           rd_four;
        logic           addon_rst;
        logic           clr_a2p;
        logic           clr_p2a;
        logic           clr_mbox;
        bmcs_nv_state_t nv_state;
        logic [1:0]     nv_code;
        logic [7:0]     nv_data;
        logic [15:0]    nv_addr;
        logic           ob_en;
        logic [1:0]     ob_sel;
        logic [1:0]     ob_byte;
        logic           ob_flag;
        logic [31:0]    rdata;
        logic           rvalid;
    } bmcs_state_t;

    bmcs_state_t st;
    bmcs_state_t next_st;

    logic        hit_mcs;
    logic        hit_int;
    logic        wr_ok;
    logic        rd_ok;
    logic        ob_hit;
    logic [31:0] mcs_view;
    logic [31:0] int_view;

    assign hit_mcs = reg_addr_i == BMCS_OFS_MCS;
    assign hit_int = reg_addr_i == BMCS_OFS_INTCS;

    // Threshold gating per direction
    assign wr_ok = st.wr_en && wr_pending_i && (!st.wr_four || a2p_load4_i);
    assign rd_ok = st.rd_en && rd_pending_i && (!st.rd_four || p2a_free4_i);
    assign master_req_o    = wr_ok || rd_ok;
    assign master_dir_wr_o = wr_ok && (st.wr_prio || !rd_ok);

    // Selected mailbox and byte lane read by the Add-On
    assign ob_hit = ob_rd_i && (ob_idx_i == st.ob_sel) && ob_be_i[st.ob_byte];

    always_comb begin
        mcs_view = 32'h00000000;
        mcs_view[BMCS_B_P2A_FULL]   = p2a_full_i;
        mcs_view[BMCS_B_P2A_FREE4]  = p2a_free4_i;
        mcs_view[BMCS_B_P2A_EMPTY]  = p2a_empty_i;
        mcs_view[BMCS_B_A2P_FULL]   = a2p_full_i;
        mcs_view[BMCS_B_A2P_LOAD4]  = a2p_load4_i;
        mcs_view[BMCS_B_A2P_EMPTY]  = a2p_empty_i;
        mcs_view[BMCS_B_P2A_TCZERO] = p2a_tczero_i;
        mcs_view[BMCS_B_A2P_TCZERO] = a2p_tczero_i;
        mcs_view[BMCS_B_WR_PRIO]    = st.wr_prio;
        mcs_view[BMCS_B_WR_EN]      = st.wr_en;
        mcs_view[BMCS_B_WR_FOUR]    = st.wr_four;
        mcs_view[BMCS_B_RD_EN]      = st.rd_en;
        mcs_view[BMCS_B_RD_FOUR]    = st.rd_four;
        mcs_view[BMCS_B_NV_DATA_LO +: 8] = st.nv_data;
        mcs_view[BMCS_B_ADDON_RST]  = st.addon_rst;
        mcs_view[BMCS_B_NV_CODE_LO +: 2] = st.nv_code;
        mcs_view[BMCS_B_NV_GO]      = st.nv_state != BMCS_NV_IDLE;
    end

    always_comb begin
        int_view = 32'h00000000;
        int_view[BMCS_B_OB_BYTE_LO +: 2] = st.ob_byte;
        int_view[BMCS_B_OB_SEL_LO +: 2]  = st.ob_sel;
        int_view[BMCS_B_OB_EN]           = st.ob_en;
        int_view[BMCS_B_OB_FLAG]         = st.ob_flag;
        int_view[BMCS_B_INT_ANY]         = st.ob_flag;
    end

    always_comb begin
        next_st = st;
        next_st.clr_a2p  = 1'b0;
        next_st.clr_p2a  = 1'b0;
        next_st.clr_mbox = 1'b0;
        next_st.rvalid   = reg_rd_i;
        next_st.rdata    = 32'h00000000;
        if (reg_rd_i) begin
            if (hit_mcs) begin
                next_st.rdata = mcs_view;
            end else if (hit_int) begin
                next_st.rdata = int_view;
            end
        end

        if (reg_wr_i && hit_mcs) begin
            if (reg_be_i[1]) begin
                next_st.wr_prio = reg_wdata_i[BMCS_B_WR_PRIO];
                next_st.wr_en   = reg_wdata_i[BMCS_B_WR_EN];
                next_st.wr_four = reg_wdata_i[BMCS_B_WR_FOUR];
                next_st.rd_en   = reg_wdata_i[BMCS_B_RD_EN];
                next_st.rd_four = reg_wdata_i[BMCS_B_RD_FOUR];
            end
            if (reg_be_i[3]) begin
                next_st.addon_rst = reg_wdata_i[BMCS_B_ADDON_RST];
                next_st.clr_a2p   = reg_wdata_i[BMCS_B_CLR_A2P];
                next_st.clr_p2a   = reg_wdata_i[BMCS_B_CLR_P2A];
                next_st.clr_mbox  = reg_wdata_i[BMCS_B_CLR_MBOX];
            end
            // Busy store keeps its byte and code untouched
            if (st.nv_state == BMCS_NV_IDLE) begin
                if (reg_be_i[2]) begin
                    next_st.nv_data = reg_wdata_i[BMCS_B_NV_DATA_LO +: 8];
                end
                if (reg_be_i[3] && reg_wdata_i[BMCS_B_NV_GO]) begin
                    next_st.nv_code = reg_wdata_i[BMCS_B_NV_CODE_LO +: 2];
                    next_st.nv_state = reg_wdata_i[BMCS_B_NV_CODE_LO + 1] ? BMCS_NV_ACCESS : BMCS_NV_LOAD;
                end
            end
        end

        // Address loads take one busy cycle; software orders the two loads
        unique case (st.nv_state)
            BMCS_NV_IDLE: begin
            end
            BMCS_NV_LOAD: begin
                if (st.nv_code == BMCS_NV_LOAD_LO) begin
                    next_st.nv_addr[7:0] = st.nv_data;
                end else begin
                    next_st.nv_addr[15:8] = st.nv_data;
                end
                next_st.nv_state = BMCS_NV_IDLE;
            end
            BMCS_NV_ACCESS: begin
                if (nv_done_i) begin
                    if (st.nv_code == BMCS_NV_READ) begin
                        next_st.nv_data = nv_rdata_i;
                    end
                    next_st.nv_state = BMCS_NV_IDLE;
                end
            end
        endcase

        if (reg_wr_i && hit_int) begin
            if (reg_be_i[0]) begin
                next_st.ob_en   = reg_wdata_i[BMCS_B_OB_EN];
                next_st.ob_sel  = reg_wdata_i[BMCS_B_OB_SEL_LO +: 2];
                next_st.ob_byte = reg_wdata_i[BMCS_B_OB_BYTE_LO +: 2];
            end
            if (reg_be_i[2] && reg_wdata_i[BMCS_B_OB_FLAG]) begin
                next_st.ob_flag = 1'b0;
            end
        end
        // Set after clear so a same-cycle read is not lost
        if (ob_hit) begin
            next_st.ob_flag = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '{nv_state: BMCS_NV_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o      = st.rdata;
    assign reg_rvalid_o     = st.rvalid;
    assign addon_reset_o    = st.addon_rst;
    assign clr_a2p_flags_o  = st.clr_a2p;
    assign clr_p2a_flags_o  = st.clr_p2a;
    assign clr_mbox_flags_o = st.clr_mbox;
    assign pci_int_o        = st.ob_en && st.ob_flag;
    assign nv_req_o         = st.nv_state == BMCS_NV_ACCESS;
    assign nv_we_o          = st.nv_code == BMCS_NV_WRITE;
    assign nv_addr_o        = st.nv_addr;
    assign nv_wdata_o       = st.nv_data;

endmodule : bmcs_regs

// *** sim/bmcs_regs_properties.sv ***
// Port assertions for the bus master control/status bank.
// Assumes one clock domain; bound onto every bmcs_regs.
module bmcs_regs_checker (
    // Clock, reset, register port
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    // Request, controls, mailbox, store
    input wire logic        wr_pending_i,
    input wire logic        rd_pending_i,
    input wire logic        master_req_o,
    input wire logic        master_dir_wr_o,
    input wire logic        clr_a2p_flags_o,
    input wire logic        ob_rd_i,
    input wire logic        pci_int_o,
    input wire logic        nv_req_o,
    input wire logic        nv_done_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_unmapped_rd; reg_rd_i && reg_addr_i != 8'h3C && reg_addr_i != 8'h40; endsequence
    sequence s_nv_done; nv_req_o && nv_done_i; endsequence
    property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_unmapped; s_unmapped_rd |=> reg_rdata_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_no_req; !wr_pending_i && !rd_pending_i |-> !master_req_o; endproperty
    a_no_req: assert property (p_no_req) else $error("request without work");
    property p_dir; master_dir_wr_o |-> master_req_o && wr_pending_i; endproperty
    a_dir: assert property (p_dir) else $error("write direction without cause");
    // Enable written after the flag may also raise it
    property p_int; $rose(pci_int_o) |-> $past(ob_rd_i, 2) || $past(ob_rd_i) || $past(reg_wr_i); endproperty
    a_int: assert property (p_int) else $error("interrupt without mailbox read");
    property p_clr; $rose(clr_a2p_flags_o) |-> $past(reg_wr_i) ##1 !clr_a2p_flags_o; endproperty
    a_clr: assert property (p_clr) else $error("flag clear not a write pulse");
    property p_nv_start; $rose(nv_req_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2); endproperty
    a_nv_start: assert property (p_nv_start) else $error("store access without start");
    property p_nv_end; s_nv_done |=> !nv_req_o; endproperty
    a_nv_end: assert property (p_nv_end) else $error("store request after done");
endmodule : bmcs_regs_checker

bind bmcs_regs bmcs_regs_checker u_chk (.*);

// *** sim/bmcs_nv_model.sv ***
// Behavioural external nonvolatile store, one byte access at a time.
// Assumes the request is held until the done pulse.
module bmcs_nv_model (
    // Clock and store port
    input  wire logic        clock_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    output logic             done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] a_q;
    logic [7:0]  d_q;
    int          cnt = 0;
    bit          slow = 1'b1;
    initial {done_o, rdata_o} = 9'h0;
    always @(posedge clock_i) begin
        done_o <= 1'b0;
        rdata_o <= ~rdata_o;  // Released bus never holds a byte
        if (req_i && !done_o) begin
            cnt++;
            if (cnt >= (slow ? 6 : 1)) begin
                done_o <= 1'b1;
                cnt = 0;
                slow = ~slow;
                if (we_i) begin
                    a_q <= addr_i;
                    d_q <= wdata_i;
                end else begin
                    rdata_o <= (addr_i === a_q) ? d_q : 8'hFF;
                end
            end
        end
    end
endmodule : bmcs_nv_model

// *** sim/test_bus_master_control_status.sv ***
// Self-checking bench for the bus master control/status bank.
// Assumes bmcs_regs, its checker and the store model are compiled first.
module test_bus_master_control_status;
    timeunit 1ns;
    timeprecision 1ps;
    import bmcs_pkg::*;
    logic        clock_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, ob_rd_i = 0;
    logic [7:0]  reg_addr_i = 0, st = 8'hE6, nv_wdata_o, nv_rdata_i;
    logic [3:0]  reg_be_i = 0, ob_be_i = 0;
    logic [1:0]  ob_idx_i = 0, pend = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, rd_q, rnd;
    logic [15:0] nv_addr_o;
    logic        reg_rvalid_o, master_req_o, master_dir_wr_o, addon_reset_o, clr_a2p_flags_o, clr_p2a_flags_o;
    logic        clr_mbox_flags_o, pci_int_o, nv_req_o, nv_we_o, nv_done_i, wr_pending_i, rd_pending_i;
    logic        p2a_full_i, p2a_free4_i, p2a_empty_i, a2p_full_i, a2p_load4_i, a2p_empty_i, p2a_tczero_i, a2p_tczero_i;
    int          seed = 78, err_count = 0, compares = 0;
    assign {a2p_tczero_i, p2a_tczero_i, a2p_empty_i, a2p_load4_i, a2p_full_i, p2a_empty_i, p2a_free4_i, p2a_full_i} = st;
    assign {wr_pending_i, rd_pending_i} = pend;
    always #5 clock_i = ~clock_i;
    bmcs_regs u_dut (.*);
    bmcs_nv_model u_nv (.clock_i(clock_i), .req_i(nv_req_o), .we_i(nv_we_o), .addr_i(nv_addr_o),
        .wdata_i(nv_wdata_o), .rdata_o(nv_rdata_i), .done_o(nv_done_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_be_i <= be;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        chk(reg_rvalid_o, 1, "rvalid");
        rd_q = reg_rdata_o;
    endtask : rd
    task automatic ob(input logic [1:0] i, input logic [3:0] be);
        @(posedge clock_i);
        ob_rd_i <= 1'b1;
        ob_idx_i <= i;
        ob_be_i <= be;
        @(posedge clock_i);
        ob_rd_i <= 1'b0;
    endtask : ob
    // Software waits for ready before the next access
    task automatic nv_wait;
        repeat (20) begin
            rd(BMCS_OFS_MCS);
            if (rd_q[31] === 1'b0) return;
        end
        chk(rd_q[31], 0, "store stuck busy");
    endtask : nv_wait
    function automatic logic [1:0] exp_req(input logic [7:0] c, input logic [1:0] p, input logic [7:0] s);
        logic w, r;
        w = c[2] & p[1] & (~c[3] | s[4]);
        r = c[6] & p[0] & (~c[7] | s[1]);
        return {w | r, w & (c[0] | ~r)};
    endfunction : exp_req
    task automatic finish_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(BMCS_OFS_MCS);
        chk(rd_q, BMCS_MCS_RESET, "mcs reset");
        rd(BMCS_OFS_INTCS);
        chk(rd_q, 0, "int reset");
        rd(8'h44);
        chk(rd_q, 0, "unmapped");
        $display("reset test done");
        for (int k = 0; k < 24; k++) begin
            rnd = $random(seed);
            @(posedge clock_i);
            st <= rnd[7:0];
            pend <= rnd[9:8];
            wr(BMCS_OFS_MCS, 4'h2, {16'h0, rnd[23:16], 8'h0});
            @(negedge clock_i);
            chk({master_req_o, master_dir_wr_o}, exp_req(rnd[23:16], rnd[9:8], rnd[7:0]), "request");
            rd(BMCS_OFS_MCS);
            chk(rd_q[15:0] & 16'hCDFF, {rnd[23:16] & 8'hCD, rnd[7:0]}, "mcs view");
        end
        $display("request test done");
        for (int k = 0; k < 8; k++) begin
            rnd = $random(seed);
            wr(BMCS_OFS_INTCS, 4'h1, {27'h0, rnd[4:0]});
            ob(rnd[5] ? rnd[3:2] + 2'h1 : rnd[3:2], rnd[5] ? 4'hF : ~(4'h1 << rnd[1:0]));
            rd(BMCS_OFS_INTCS);
            chk(rd_q, {27'h0, rnd[4:0]}, "wrong mailbox");
            ob(rnd[3:2], 4'h1 << rnd[1:0]);
            wr(BMCS_OFS_INTCS, 4'h5, {27'h0, rnd[4:0]});
            rd(BMCS_OFS_INTCS);
            chk(rd_q, {16'h81, 11'h0, rnd[4:0]}, "mailbox flag");
            chk(pci_int_o, rnd[4], "pci interrupt");
            wr(BMCS_OFS_INTCS, 4'h4, 32'h10000);
            rd(BMCS_OFS_INTCS);
            chk(rd_q, {27'h0, rnd[4:0]}, "flag clear");
        end
        // Read of the selected byte and a clear land on one edge
        fork
            wr(BMCS_OFS_INTCS, 4'h4, 32'h10000);
            ob(rnd[3:2], 4'h1 << rnd[1:0]);
        join
        rd(BMCS_OFS_INTCS);
        chk(rd_q, {16'h81, 11'h0, rnd[4:0]}, "set wins over clear");
        $display("mailbox test done");
        wr(BMCS_OFS_MCS, 4'h8, 32'h0F000000);
        @(negedge clock_i);
        chk({addon_reset_o, clr_a2p_flags_o, clr_p2a_flags_o, clr_mbox_flags_o}, 4'hF, "controls");
        @(negedge clock_i);
        chk({addon_reset_o, clr_a2p_flags_o, clr_p2a_flags_o, clr_mbox_flags_o}, 4'h8, "pulses end");
        wr(BMCS_OFS_MCS, 4'h8, 32'h0);
        $display("control test done");
        wr(BMCS_OFS_MCS, 4'hC, 32'h80120000);
        nv_wait;
        wr(BMCS_OFS_MCS, 4'hC, 32'hA0340000);
        nv_wait;
        wr(BMCS_OFS_MCS, 4'hC, 32'hC0560000);
        @(negedge clock_i);
        chk({nv_req_o, nv_we_o, nv_addr_o, nv_wdata_o}, {2'h3, 16'h3412, 8'h56}, "store write");
        wr(BMCS_OFS_MCS, 4'hC, 32'h80990000);
        nv_wait;
        wr(BMCS_OFS_MCS, 4'hC, 32'hE0000000);
        nv_wait;
        chk({rd_q[31:29], rd_q[23:16]}, {3'h3, 8'h56}, "store read");
        $display("store test done");
        // Mid-run reset must drop every written field and the flag
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(BMCS_OFS_MCS);
        chk(rd_q[31:8], 32'h0, "mcs after reset");
        rd(BMCS_OFS_INTCS);
        chk(rd_q, 32'h0, "int after reset");
        $display("second reset test done");
        finish_test;
    end
endmodule : test_bus_master_control_status
